// ### dv/link_err_chk.sv
// Checker: port assertions for the link status and error register bank
`timescale 1ns/1ps
module link_err_chk (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        por_rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_hit,
  input wire logic        ev_malformed,
  input wire logic [4:0]  ev_rx_fault,
  input wire logic        fatal_report,
  input wire logic [31:0] fatal_report_vec,
  input wire logic        receiver_fault_flag
);
  // ****************************************
  // Helpers, sequences and properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (srst || por_rst);
  logic mapped, rx_any, clr0;
  // Exact offsets only, the window has no aliases
  assign mapped = reg_addr inside {12'h08A, 12'h1C4, 12'h1C8, 12'h1D0};
  assign rx_any = |ev_rx_fault;
  assign clr0   = reg_wr && reg_addr == 12'h1D0 && reg_wdata[0];
  sequence s_rd_fatal; reg_rd && reg_addr == 12'h1C4; endsequence
  sequence s_rd_rec; reg_rd && reg_addr == 12'h1D0; endsequence
  sequence s_rd_link; reg_rd && reg_addr == 12'h08A; endsequence
  property p_hit; reg_rd |=> reg_hit == $past(mapped); endproperty
  property p_quiet; !reg_rd |=> reg_rdata == 32'h0 && !reg_hit; endproperty
  property p_fatal_rsv;
    s_rd_fatal |=> (reg_rdata & ~link_err_pkg::FATAL_IMPL_MASK) == 32'h0;
  endproperty
  property p_rec_rsv;
    s_rd_rec |=> (reg_rdata & ~link_err_pkg::REC_IMPL_MASK) == 32'h0;
  endproperty
  property p_link; s_rd_link |=> reg_rdata[31:10] == 22'h0; endproperty
  property p_vec;
    fatal_report |-> (fatal_report_vec & ~link_err_pkg::FATAL_IMPL_MASK) == 32'h0;
  endproperty
  property p_cause; fatal_report_vec[18] |-> $past(ev_malformed); endproperty
  // Ordinary reset does not touch the sticky flag, so every rise needs a source
  property p_rx_set; $rose(receiver_fault_flag) |-> $past(rx_any); endproperty
  property p_rx_clr; $fell(receiver_fault_flag) |-> $past(clr0); endproperty
  a_hit: assert property (p_hit) else $error("read hit wrong");
  a_quiet: assert property (p_quiet) else $error("read data outside read");
  a_fatal_rsv: assert property (p_fatal_rsv) else $error("fatal reserved bit");
  a_rec_rsv: assert property (p_rec_rsv) else $error("recoverable reserved bit");
  a_link: assert property (p_link) else $error("link report high bits");
  a_vec: assert property (p_vec) else $error("report vector bad bit");
  a_cause: assert property (p_cause) else $error("report without event");
  a_rx_set: assert property (p_rx_set) else $error("receiver flag set alone");
  a_rx_clr: assert property (p_rx_clr) else $error("receiver flag cleared alone");
endmodule : link_err_chk

bind link_status_error_regs link_err_chk u_chk (.clock(clock), .srst(srst), .por_rst(por_rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .ev_malformed(ev_malformed),
  .ev_rx_fault(ev_rx_fault), .fatal_report(fatal_report),
  .fatal_report_vec(fatal_report_vec), .receiver_fault_flag(receiver_fault_flag));

// ### dv/link_phy_model.sv
// Partner model: link layers feeding link state and error event pulses
`timescale 1ns/1ps
module link_phy_model (
  input  wire logic        clock,
  input  wire logic [14:0] inject,
  output      logic [5:0]  lane_count,
  output      logic [3:0]  link_rate,
  output      logic [5:0]  fatal_ev,
  output      logic [3:0]  rec_ev,
  output      logic [4:0]  rx_ev
);
  // ****************************************
  // Trained link and error detection
  // ****************************************
  // Trained link stays at four lanes and the base rate
  assign lane_count = 6'h04;
  assign link_rate  = 4'h1;
  // Each requested error leaves as a one-cycle pulse after the edge
  always_ff @(posedge clock) begin
    {rx_ev, rec_ev, fatal_ev} <= inject;
  end
endmodule : link_phy_model

// ### dv/link_status_error_regs_bench.sv
// Testbench: register access, sticky error flags and fatal reporting
`timescale 1ns/1ps
module link_status_error_regs_bench;
  // ****************************************
  // Signals, partner and design
  // ****************************************
  logic        clock, srst, por_rst, reg_wr, reg_rd, reg_hit, fatal_report, receiver_fault_flag;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, fatal_vec, exp_fatal;
  logic [14:0] inject;
  logic [5:0]  lane, fatal_ev;
  logic [3:0]  rate, rec_ev;
  logic [4:0]  rx_ev;
  int          fails, checks_done, fpos[6] = '{20, 18, 17, 16, 14, 4}, rpos[4] = '{12, 8, 7, 6};
  link_phy_model u_phy (.clock(clock), .inject(inject), .lane_count(lane), .link_rate(rate),
    .fatal_ev(fatal_ev), .rec_ev(rec_ev), .rx_ev(rx_ev));
  link_status_error_regs u_dut (.clock(clock), .srst(srst), .por_rst(por_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .negotiated_lane_count(lane),
    .current_link_rate(rate), .ev_unsup_req(fatal_ev[0]), .ev_malformed(fatal_ev[1]),
    .ev_rx_overflow(fatal_ev[2]), .ev_unexp_cpl(fatal_ev[3]), .ev_cpl_timeout(fatal_ev[4]),
    .ev_dl_proto(fatal_ev[5]), .ev_replay_tmo(rec_ev[0]), .ev_replay_roll(rec_ev[1]),
    .ev_bad_dllp(rec_ev[2]), .ev_bad_tlp(rec_ev[3]), .ev_rx_fault(rx_ev),
    .fatal_report(fatal_report), .fatal_report_vec(fatal_vec),
    .receiver_fault_flag(receiver_fault_flag));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stands one cycle only, so it is sampled just after the edge
  task automatic rd(logic [11:0] a, logic [31:0] exp, logic hit);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("read data", exp, reg_rdata);
    chk("read hit", {31'h0, hit}, {31'h0, reg_hit});
  endtask : rd
  task automatic fire(logic [14:0] v, logic [31:0] rep);
    @(posedge clock);
    inject <= v;
    @(posedge clock);
    inject <= 15'h0;
    @(posedge clock);
    #1;
    chk("report vector", rep, fatal_vec);
    chk("report pulse", {31'h0, |rep}, {31'h0, fatal_report});
  endtask : fire
  task automatic hold_reset(logic por);
    @(posedge clock);
    srst    <= !por;
    por_rst <= por;
    repeat (6) @(posedge clock);
    srst    <= 1'b0;
    por_rst <= 1'b0;
  endtask : hold_reset
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    stop_test;
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, inject} = '0;
    srst = 1'b1;
    por_rst = 1'b1;
    hold_reset(1'b1);
    rd(12'h1C4, 32'h0, 1'b1);
    rd(12'h1C8, 32'h0, 1'b1);
    rd(12'h08A, 32'h0000_0041, 1'b1);
    wr(12'h08A, 32'hFFFF_FFFF);
    rd(12'h08A, 32'h0000_0041, 1'b1);
    rd(12'h1CC, 32'h0, 1'b0);
    exp_fatal = '0;
    for (int i = 0; i < 6; i++) begin
      fire(15'h1 << i, 32'h1 << fpos[i]);
      exp_fatal[fpos[i]] = 1'b1;
    end
    rd(12'h1C4, exp_fatal, 1'b1);
    wr(12'h1C4, 32'hFFEC_BFFF);
    rd(12'h1C4, 32'h0013_4000, 1'b1);
    wr(12'h1C8, 32'hFFFF_FFFF);
    rd(12'h1C8, 32'h0017_4010, 1'b1);
    fire(15'h0002, 32'h0);
    rd(12'h1C4, 32'h0017_4000, 1'b1);
    // Each recoverable source alone, cleared by writing all ones
    for (int i = 6; i < 15; i++) begin
      fire(15'h1 << i, 32'h0);
      rd(12'h1D0, i < 10 ? 32'h1 << rpos[i - 6] : 32'h1, 1'b1);
      wr(12'h1D0, 32'hFFFF_FFFF);
    end
    rd(12'h1D0, 32'h0, 1'b1);
    fire(15'h7C00, 32'h0);
    hold_reset(1'b0);
    rd(12'h1C4, 32'h0017_4000, 1'b1);
    rd(12'h1C8, 32'h0017_4010, 1'b1);
    rd(12'h1D0, 32'h1, 1'b1);
    chk("receiver flag", 32'h1, {31'h0, receiver_fault_flag});
    hold_reset(1'b1);
    rd(12'h1C4, 32'h0, 1'b1);
    rd(12'h1C8, 32'h0, 1'b1);
    rd(12'h1D0, 32'h0, 1'b1);
    chk("receiver flag", 32'h0, {31'h0, receiver_fault_flag});
    stop_test;
  end
endmodule : link_status_error_regs_bench

// ### logic/link_err_pkg.sv
// Package: register map, field positions and reset values of the link status and error bank
package link_err_pkg;

  // ****************************************************************
  // Register offsets (byte offsets in the memory-mapped window)
  // ****************************************************************
  localparam logic [11:0] LINK_STATE_REPORT_OFS       = 12'h08A;
  localparam logic [11:0] FATAL_FAULT_FLAGS_OFS       = 12'h1C4;
  localparam logic [11:0] FATAL_FAULT_SUPPRESS_OFS    = 12'h1C8;
  localparam logic [11:0] RECOVERABLE_FAULT_FLAGS_OFS = 12'h1D0;

  // ****************************************************************
  // Link state report fields
  // ****************************************************************
  localparam int          LANE_COUNT_LSB  = 4;
  localparam int          LANE_COUNT_W    = 6;
  localparam int          LINK_RATE_LSB   = 0;
  localparam int          LINK_RATE_W     = 4;
  localparam logic [5:0]  LANE_COUNT_X4   = 6'h04;
  localparam logic [3:0]  LINK_RATE_2G5   = 4'h1;
  localparam logic [15:0] LINK_STATE_RST  = 16'h0001;

  // ****************************************************************
  // Fatal fault bit positions
  // ****************************************************************
  localparam int FATAL_UNSUP_REQ_BIT  = 20;
  localparam int FATAL_MALFORMED_BIT  = 18;
  localparam int FATAL_RX_OVERFLOW_BIT = 17;
  localparam int FATAL_UNEXP_CPL_BIT  = 16;
  localparam int FATAL_CPL_TIMEOUT_BIT = 14;
  localparam int FATAL_DL_PROTO_BIT   = 4;
  localparam logic [31:0] FATAL_IMPL_MASK = 32'h0017_4010;
  localparam logic [31:0] FATAL_FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] FATAL_SUPP_RST  = 32'h0000_0000;

  // ****************************************************************
  // Recoverable fault bit positions
  // ****************************************************************
  localparam int REC_REPLAY_TMO_BIT   = 12;
  localparam int REC_REPLAY_ROLL_BIT  = 8;
  localparam int REC_BAD_DLLP_BIT     = 7;
  localparam int REC_BAD_TLP_BIT      = 6;
  localparam int REC_RX_FAULT_BIT     = 0;
  localparam logic [31:0] REC_IMPL_MASK   = 32'h0000_11C1;
  localparam logic [31:0] REC_FLAGS_RST   = 32'h0000_0000;

  // Number of receiver fault sources folded into one flag
  localparam int RX_FAULT_SRC_N = 5;

endpackage : link_err_pkg

// ### logic/link_status_error_regs.sv
// Link status report and sticky error status/mask register bank
`timescale 1ns/1ps
module link_status_error_regs (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        por_rst,
  // Register access port (byte address inside the window)
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output      logic [31:0] reg_rdata,
  output      logic        reg_hit,
  // Link state from the physical layer
  input  wire logic [5:0]  negotiated_lane_count,
  input  wire logic [3:0]  current_link_rate,
  // Fatal error event pulses
  input  wire logic        ev_unsup_req,
  input  wire logic        ev_malformed,
  input  wire logic        ev_rx_overflow,
  input  wire logic        ev_unexp_cpl,
  input  wire logic        ev_cpl_timeout,
  input  wire logic        ev_dl_proto,
  // Recoverable error event pulses
  input  wire logic        ev_replay_tmo,
  input  wire logic        ev_replay_roll,
  input  wire logic        ev_bad_dllp,
  input  wire logic        ev_bad_tlp,
  input  wire logic [4:0]  ev_rx_fault,
  // Reporting toward the error signalling logic
  output      logic        fatal_report,
  output      logic [31:0] fatal_report_vec,
  output      logic        receiver_fault_flag
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] suppress;
    logic [15:0] link_state;
    logic [31:0] rdata;
    logic        hit;
    logic [31:0] report_vec;
    logic        report;
  } state_s;

  state_s      state_q;
  state_s      state_d;
  logic [31:0] fatal_flags;
  logic [31:0] rec_flags;
  logic [31:0] fatal_set;
  logic [31:0] rec_set;
  logic        wr_fatal;
  logic        wr_rec;

  // Decode of a register offset, used by both read and write paths
  function automatic logic is_reg(input logic [11:0] addr, input logic [11:0] ofs);
    is_reg = (addr == ofs);
  endfunction : is_reg

  // ****************************************************************
  // Event collection
  // ****************************************************************
  always_comb begin
    fatal_set = '0;
    fatal_set[link_err_pkg::FATAL_UNSUP_REQ_BIT]   = ev_unsup_req;
    fatal_set[link_err_pkg::FATAL_MALFORMED_BIT]   = ev_malformed;
    fatal_set[link_err_pkg::FATAL_RX_OVERFLOW_BIT] = ev_rx_overflow;
    fatal_set[link_err_pkg::FATAL_UNEXP_CPL_BIT]   = ev_unexp_cpl;
    fatal_set[link_err_pkg::FATAL_CPL_TIMEOUT_BIT] = ev_cpl_timeout;
    fatal_set[link_err_pkg::FATAL_DL_PROTO_BIT]    = ev_dl_proto;
  end

  // Receiver fault folds decode, framing, deskew and elastic buffer faults
  always_comb begin
    rec_set = '0;
    rec_set[link_err_pkg::REC_REPLAY_TMO_BIT]  = ev_replay_tmo;
    rec_set[link_err_pkg::REC_REPLAY_ROLL_BIT] = ev_replay_roll;
    rec_set[link_err_pkg::REC_BAD_DLLP_BIT]    = ev_bad_dllp;
    rec_set[link_err_pkg::REC_BAD_TLP_BIT]     = ev_bad_tlp;
    rec_set[link_err_pkg::REC_RX_FAULT_BIT]    = |ev_rx_fault;
  end

  assign wr_fatal = reg_wr && is_reg(reg_addr, link_err_pkg::FATAL_FAULT_FLAGS_OFS);
  assign wr_rec   = reg_wr && is_reg(reg_addr, link_err_pkg::RECOVERABLE_FAULT_FLAGS_OFS);

  // ****************************************************************
  // Sticky flag registers
  // ****************************************************************
  sticky_w1c_bits #(
    .WIDTH (32),
    .IMPL  (link_err_pkg::FATAL_IMPL_MASK)
  ) u_fatal_flags (
    .clock      (clock),
    .por_rst    (por_rst),
    .event_set  (fatal_set),
    .clear_en   (wr_fatal),
    .clear_bits (reg_wdata),
    .flags      (fatal_flags)
  );

  sticky_w1c_bits #(
    .WIDTH (32),
    .IMPL  (link_err_pkg::REC_IMPL_MASK)
  ) u_rec_flags (
    .clock      (clock),
    .por_rst    (por_rst),
    .event_set  (rec_set),
    .clear_en   (wr_rec),
    .clear_bits (reg_wdata),
    .flags      (rec_flags)
  );

  // ****************************************************************
  // Next state: suppress register, link report, read data, reporting
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    // Suppress bits exist only where a fatal flag exists
    if (reg_wr && is_reg(reg_addr, link_err_pkg::FATAL_FAULT_SUPPRESS_OFS)) begin
      state_d.suppress = reg_wdata & link_err_pkg::FATAL_IMPL_MASK;
    end
    // Link report tracks the physical layer; upper bits stay zero
    state_d.link_state = '0;
    state_d.link_state[link_err_pkg::LANE_COUNT_LSB +: link_err_pkg::LANE_COUNT_W] =
      negotiated_lane_count;
    state_d.link_state[link_err_pkg::LINK_RATE_LSB +: link_err_pkg::LINK_RATE_W] =
      current_link_rate;
    // Read data registered; unmapped offsets answer zero with no hit
    state_d.rdata = '0;
    state_d.hit   = 1'b0;
    if (reg_rd) begin
      if (is_reg(reg_addr, link_err_pkg::LINK_STATE_REPORT_OFS)) begin
        state_d.rdata = {16'h0000, state_q.link_state};
        state_d.hit   = 1'b1;
      end else if (is_reg(reg_addr, link_err_pkg::FATAL_FAULT_FLAGS_OFS)) begin
        state_d.rdata = fatal_flags;
        state_d.hit   = 1'b1;
      end else if (is_reg(reg_addr, link_err_pkg::FATAL_FAULT_SUPPRESS_OFS)) begin
        state_d.rdata = state_q.suppress;
        state_d.hit   = 1'b1;
      end else if (is_reg(reg_addr, link_err_pkg::RECOVERABLE_FAULT_FLAGS_OFS)) begin
        state_d.rdata = rec_flags;
        state_d.hit   = 1'b1;
      end
    end
    // Only unsuppressed new fatal events are passed on
    state_d.report_vec = fatal_set & ~state_q.suppress;
    state_d.report     = |(fatal_set & ~state_q.suppress);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // One register for the whole state; ordinary reset spares the sticky suppress bits
  always_ff @(posedge clock) begin
    if (por_rst) begin
      state_q <= '{suppress:   link_err_pkg::FATAL_SUPP_RST,
                   link_state: link_err_pkg::LINK_STATE_RST,
                   rdata:      32'h0000_0000,
                   hit:        1'b0,
                   report_vec: 32'h0000_0000,
                   report:     1'b0};
    end else if (srst) begin
      state_q <= '{suppress:   state_q.suppress,
                   link_state: link_err_pkg::LINK_STATE_RST,
                   rdata:      32'h0000_0000,
                   hit:        1'b0,
                   report_vec: 32'h0000_0000,
                   report:     1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata           = state_q.rdata;
  assign reg_hit             = state_q.hit;
  assign fatal_report        = state_q.report;
  assign fatal_report_vec    = state_q.report_vec;
  assign receiver_fault_flag = rec_flags[link_err_pkg::REC_RX_FAULT_BIT];

endmodule : link_status_error_regs

// ### logic/sticky_w1c_bits.sv
// Sticky write-one-to-clear flag vector, reset only by the power-on reset
`timescale 1ns/1ps
module sticky_w1c_bits #(
  parameter int          WIDTH = 32,
  parameter logic [31:0] IMPL  = 32'h0000_0000
) (
  input  wire logic             clock,
  input  wire logic             por_rst,
  input  wire logic [WIDTH-1:0] event_set,
  input  wire logic             clear_en,
  input  wire logic [WIDTH-1:0] clear_bits,
  output      logic [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } state_s;

  state_s state_q;
  state_s state_d;

  // A set in the same cycle as its clear wins, so no event is dropped
  always_comb begin
    state_d = state_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (IMPL[i]) begin
        if (event_set[i]) begin
          state_d.flags[i] = 1'b1;
        end else if (clear_en && clear_bits[i]) begin
          state_d.flags[i] = 1'b0;
        end
      end else begin
        state_d.flags[i] = 1'b0;
      end
    end
  end

  // Only the power-on reset reaches these flops, ordinary resets do not
  always_ff @(posedge clock) begin
    if (por_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flags = state_q.flags;

endmodule : sticky_w1c_bits
